// ===== hw/adc_port_pkg.sv
`default_nettype none
package adc_port_pkg;
    // ==========================================================
    // Word lengths and exchange framing
    localparam int WORD_MAX = 17;
    localparam int SIGN_BIT = 12;
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_12 = 5'h0C;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_17 = 5'h11;
    localparam logic [4:0] LEN_DEFAULT = 5'h0D;
    localparam logic [4:0] CMD_LAST = 5'h07;

    // ==========================================================
    // Instruction bit positions (first bit in is bit 0)
    localparam int BIT_OPT0 = 0;
    localparam int BIT_OPT1 = 1;
    localparam int BIT_KIND = 4;
    localparam int BIT_LSB = 5;
    localparam int BIT_SZ_A = 6;
    localparam int BIT_SZ_B = 7;

    // Non-conversion opcodes, bits 5..7 read as a number, bit 5 the most significant
    localparam logic [2:0] OP_CAL = 3'h0;
    localparam logic [2:0] OP_ZERO = 3'h1;
    localparam logic [2:0] OP_UP = 3'h2;
    localparam logic [2:0] OP_DOWN = 3'h3;
    localparam logic [2:0] OP_STATUS = 3'h4;
    localparam logic [2:0] OP_SIGN = 3'h5;
    localparam logic [2:0] OP_ACQ = 3'h6;
    localparam logic [2:0] OP_MODE = 3'h7;

    // ==========================================================
    // Status word bit positions
    localparam int ST_UP = 0;
    localparam int ST_DOWN = 1;
    localparam int ST_CAL = 2;
    localparam int ST_SZ8 = 3;
    localparam int ST_SZ12 = 4;
    localparam int ST_SZ16 = 5;
    localparam int ST_SIGN = 6;
    localparam int ST_MSB = 7;
    localparam int ST_TEST = 8;

    // ==========================================================
    // Sequence lengths in conversion clock cycles
    localparam logic [15:0] ACQ_6 = 16'h0006;
    localparam logic [15:0] ACQ_10 = 16'h000A;
    localparam logic [15:0] ACQ_18 = 16'h0012;
    localparam logic [15:0] ACQ_34 = 16'h0022;
    localparam logic [15:0] CONV_CYCLES = 16'h002C;
    localparam logic [15:0] ZERO_CYCLES = 16'h0010;
    localparam logic [15:0] CAL_CYCLES = 16'h03E8;
    localparam logic [15:0] PWR_CYCLES = 16'h0064;
    localparam logic [16:0] JUNK_SEED = 17'h1_5A5A;
    localparam logic [1:0] ACQ_SEL_DEFAULT = 2'h1;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {SZ8, SZ12, SZ16} size_t;
    typedef enum logic [1:0] {SHOW_RESULT, SHOW_STATUS, SHOW_JUNK} show_t;
    typedef enum logic [2:0] {
        IDLE, WAKING, SINKING, ASLEEP, ACQUIRE, CONVERT, CALIBRATE
    } core_state_t;

    typedef struct packed {
        logic selectN;
        logic readOnly;
        logic sleepPin;
    } ctrl_pins_t;

    typedef struct packed {
        size_t size;
        logic msbFirst;
        logic signOn;
    } fmt_t;

    typedef struct packed {
        logic [1:0] csSync;
        logic [1:0] roSync;
        logic [1:0] sleepSync;
        logic [1:0] tgSync;
        logic tgSeen;
        core_state_t state;
        logic [15:0] cnt;
        fmt_t fmt;
        logic [1:0] acqSel;
        logic testMode;
        logic swDown;
        logic zeroPend;
        logic calDirty;
        logic armed;
        logic [12:0] resultCode;
        show_t show;
        logic [8:0] statusSnap;
        logic [16:0] junk;
        logic [16:0] doWord;
        logic [4:0] wordLen;
        logic eoc;
    } core_t;

    typedef struct packed {
        logic [4:0] bitCnt;
        logic [4:0] len;
        logic [16:0] shreg;
        logic [6:0] cmdSh;
        logic doBit;
    } frame_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic toggle;
    } hold_t;

    localparam fmt_t FMT_DEFAULT = '{size: SZ12, msbFirst: 1'b1, signOn: 1'b1};
    localparam core_t CORE_RST = '{state: IDLE, fmt: FMT_DEFAULT, show: SHOW_RESULT,
        acqSel: ACQ_SEL_DEFAULT, junk: JUNK_SEED, wordLen: LEN_DEFAULT,
        csSync: 2'h3, eoc: 1'b1, default: '0};
endpackage
`default_nettype wire

// ===== hw/adc_serial_port.sv
`default_nettype none
// Functional notes
// - Sleep wins; select high idles; read-only converts nothing
// - Status bits 0-2 show power and calibration busy
// - Status bits 3-5 flag word length one-hot
// - Status bit 6 shows sign appended
// - Status bit 7 shows MSB-first order
// - Status bit 8 shows test mode
// - Calibration scrambles output through next status read
// - Requested status appears during the next exchange
// - Select low mid-conversion ends that conversion
// - End-of-conversion output tells host conversion finished
// - Result leaves in the exchange after completion
// - Power-on: 12+sign, MSB first, 10 cycles, user
// - Acquisition and sign instructions never start conversion
// - Channel and format instructions start a conversion
// - Acquisition of 6, 10, 18 or 34 cycles
// - Select held low needs exact counts, 13 first
// - Expected count equals the output word length
module adc_serial_port (
    input wire logic clk,
    input wire logic rstn,
    input wire logic shiftClk,
    input wire adc_port_pkg::ctrl_pins_t pins,
    input wire logic serialCommandIn,
    input wire logic [12:0] analogCode,
    output logic serialDataOut,
    output logic conversionDone
);
    import adc_port_pkg::*;

    core_t c;
    core_t next_c;
    frame_t f;
    frame_t next_f;
    hold_t h;
    hold_t next_h;
    logic linkRstN;

    // ==========================================================
    // Format helpers
    function automatic logic [4:0] baseLen(input size_t s);
        case (s)
            SZ8: return LEN_8;
            SZ16: return LEN_16;
            default: return LEN_12;
        endcase
    endfunction

    function automatic logic [4:0] fmtLen(input fmt_t fm);
        return baseLen(fm.size) + {4'h0, fm.signOn};
    endfunction

    // Left-align so the link always shifts from the top bit
    function automatic logic [16:0] alignWord(input logic [16:0] v,
                                              input logic [4:0] len,
                                              input logic msb);
        logic [16:0] r;
        r = '0;
        if (msb) begin
            r = v << (LEN_17 - len);
        end else begin
            for (int i = 0; i < WORD_MAX; i++) begin
                r[WORD_MAX - 1 - i] = v[i];
            end
        end
        return r;
    endfunction

    function automatic logic [16:0] resultBits(input logic [12:0] code,
                                               input fmt_t fm);
        logic [15:0] mag;
        logic [16:0] v;
        case (fm.size)
            SZ8: mag = {8'h00, code[11:4]};
            SZ16: mag = {code[11:0], 4'h0};
            default: mag = {4'h0, code[11:0]};
        endcase
        v = {1'b0, mag};
        if (fm.signOn) begin
            v = v | (17'(code[SIGN_BIT]) << baseLen(fm.size));
        end
        return v;
    endfunction

    function automatic logic [8:0] statusOf(input core_t s);
        logic [8:0] w;
        w = '0;
        w[ST_UP] = (s.state == WAKING);
        w[ST_DOWN] = (s.state == SINKING);
        w[ST_CAL] = (s.state == CALIBRATE);
        w[ST_SZ8] = (s.fmt.size == SZ8);
        w[ST_SZ12] = (s.fmt.size == SZ12);
        w[ST_SZ16] = (s.fmt.size == SZ16);
        w[ST_SIGN] = s.fmt.signOn;
        w[ST_MSB] = s.fmt.msbFirst;
        w[ST_TEST] = s.testMode;
        return w;
    endfunction

    function automatic logic [15:0] acqCycles(input logic [1:0] sel);
        case (sel)
            2'h0: return ACQ_6;
            2'h1: return ACQ_10;
            2'h2: return ACQ_18;
            default: return ACQ_34;
        endcase
    endfunction

    // ==========================================================
    // Link side, clocked by the host shift clock
    // Select high holds the frame in reset, so a stopped clock
    // between exchanges leaves nothing half done.
    assign linkRstN = rstn & ~pins.selectN;

    // Frame shifter; word and length from the core are loaded at
    // bit 0 only, when the core holds them still
    always_comb begin
        logic [4:0] lenNow;
        lenNow = (f.bitCnt == '0) ? c.wordLen : f.len;
        next_f = f;
        if (f.bitCnt == '0) begin
            next_f.len = c.wordLen;
            next_f.doBit = c.doWord[WORD_MAX - 1];
            next_f.shreg = c.doWord << 1;
        end else begin
            next_f.doBit = f.shreg[WORD_MAX - 1];
            next_f.shreg = f.shreg << 1;
        end
        if (f.bitCnt < CMD_LAST) begin
            next_f.cmdSh[f.bitCnt[2:0]] = serialCommandIn;
        end
        // Wrap at word length keeps back-to-back frames aligned
        if (f.bitCnt == lenNow - 5'h01) begin
            next_f.bitCnt = '0;
        end else begin
            next_f.bitCnt = f.bitCnt + 5'h01;
        end
    end

    always_ff @(posedge shiftClk or negedge linkRstN) begin
        if (!linkRstN) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // Instruction holder survives select going high
    always_comb begin
        next_h = h;
        if (f.bitCnt == CMD_LAST) begin
            next_h.cmd = {serialCommandIn, f.cmdSh};
            next_h.toggle = ~h.toggle;
        end
    end

    always_ff @(posedge shiftClk or negedge rstn) begin
        if (!rstn) begin
            h <= '0;
        end else begin
            h <= next_h;
        end
    end

    // ==========================================================
    // Core side, clocked by the conversion clock
    always_comb begin
        logic newCmd;
        logic csLow;
        logic sleep;
        logic ro;
        logic [7:0] cmd;
        logic [2:0] op;
        next_c = c;
        // Two-stage synchronisers; only the second stage is read below
        next_c.csSync = {c.csSync[0], pins.selectN};
        next_c.roSync = {c.roSync[0], pins.readOnly};
        next_c.sleepSync = {c.sleepSync[0], pins.sleepPin};
        next_c.tgSync = {c.tgSync[0], h.toggle};
        next_c.tgSeen = c.tgSync[1];
        newCmd = (c.tgSync[1] != c.tgSeen);
        csLow = ~c.csSync[1];
        sleep = c.sleepSync[1];
        ro = c.roSync[1];
        // Holder is stable for many cycles after its toggle
        cmd = h.cmd;
        op = {cmd[BIT_LSB], cmd[BIT_SZ_A], cmd[BIT_SZ_B]};
        if (c.cnt != '0) begin
            next_c.cnt = c.cnt - 16'h0001;
        end

        case (c.state)
            WAKING: begin
                if (c.cnt == '0) next_c.state = IDLE;
            end
            SINKING: begin
                if (c.cnt == '0) next_c.state = ASLEEP;
            end
            ASLEEP: begin
                if (!sleep && !c.swDown) begin
                    next_c.state = WAKING;
                    next_c.cnt = PWR_CYCLES;
                end
            end
            CALIBRATE: begin
                // Calibration reuses the output shifter
                next_c.junk = {c.junk[15:0], c.junk[16] ^ c.junk[13]};
                if (c.cnt == '0) next_c.state = IDLE;
            end
            ACQUIRE, CONVERT: begin
                if (!csLow) next_c.armed = 1'b1;
                if (c.armed && csLow) begin
                    // Early end: no result replaces the old one
                    next_c.state = IDLE;
                    next_c.eoc = 1'b1;
                    next_c.show = SHOW_JUNK;
                end else if (c.cnt == '0 && c.state == ACQUIRE) begin
                    next_c.state = CONVERT;
                    next_c.cnt = CONV_CYCLES;
                end else if (c.cnt == '0) begin
                    next_c.state = IDLE;
                    next_c.resultCode = analogCode;
                    next_c.show = SHOW_RESULT;
                    next_c.eoc = 1'b1;
                end
            end
            default: begin
                next_c.state = IDLE;
            end
        endcase

        // Instruction execution; read-only exchanges only read out
        if (newCmd && !ro && !sleep) begin
            if (!cmd[BIT_KIND]) begin
                if (c.state == IDLE) begin
                    next_c.state = ACQUIRE;
                    next_c.cnt = acqCycles(c.acqSel);
                    if (c.zeroPend) begin
                        next_c.cnt = acqCycles(c.acqSel) + ZERO_CYCLES;
                    end
                    next_c.zeroPend = 1'b0;
                    next_c.armed = 1'b0;
                    next_c.eoc = 1'b0;
                    next_c.fmt.msbFirst = ~cmd[BIT_LSB];
                    case ({cmd[BIT_SZ_A], cmd[BIT_SZ_B]})
                        2'h1: next_c.fmt.size = SZ16;
                        2'h2: next_c.fmt.size = SZ8;
                        default: next_c.fmt.size = SZ12;
                    endcase
                end
            end else begin
                case (op)
                    OP_CAL: begin
                        if (c.state == IDLE) begin
                            next_c.state = CALIBRATE;
                            next_c.cnt = CAL_CYCLES;
                            next_c.calDirty = 1'b1;
                            next_c.show = SHOW_JUNK;
                        end
                    end
                    OP_ZERO: next_c.zeroPend = 1'b1;
                    OP_UP: next_c.swDown = 1'b0;
                    OP_DOWN: begin
                        next_c.swDown = 1'b1;
                        if (c.state != ASLEEP) begin
                            next_c.state = SINKING;
                            next_c.cnt = PWR_CYCLES;
                            next_c.eoc = 1'b1;
                        end
                    end
                    OP_STATUS: begin
                        // First read after calibration still answers next time
                        next_c.calDirty = 1'b0;
                        next_c.show = SHOW_STATUS;
                        next_c.statusSnap = statusOf(c);
                    end
                    OP_SIGN: next_c.fmt.signOn = cmd[BIT_OPT0];
                    OP_ACQ: next_c.acqSel = {cmd[BIT_OPT0], cmd[BIT_OPT1]};
                    default: next_c.testMode = cmd[BIT_OPT0];
                endcase
            end
        end

        // Sleep pin forces power-down; its release also undoes a
        // software power-down
        if (sleep) begin
            next_c.swDown = 1'b0;
            if (c.state != ASLEEP && c.state != SINKING) begin
                next_c.state = SINKING;
                next_c.cnt = PWR_CYCLES;
                next_c.eoc = 1'b1;
            end
        end

        // Outgoing word rebuilt each cycle; calibration garbles it
        // until the first status read that follows
        next_c.wordLen = fmtLen(next_c.fmt);
        if (next_c.calDirty) begin
            next_c.doWord = next_c.junk;
        end else begin
            case (next_c.show)
                SHOW_RESULT: next_c.doWord = alignWord(resultBits(next_c.resultCode, next_c.fmt),
                                                       next_c.wordLen, next_c.fmt.msbFirst);
                SHOW_STATUS: next_c.doWord = alignWord({8'h00, next_c.statusSnap},
                                                       next_c.wordLen, next_c.fmt.msbFirst);
                default: next_c.doWord = next_c.junk;
            endcase
        end
    end

    // Power-on defaults come from the reset constant
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c <= CORE_RST;
        end else begin
            c <= next_c;
        end
    end

    // ==========================================================
    // Outputs, straight from flip-flops
    assign serialDataOut = f.doBit;
    assign conversionDone = c.eoc;
endmodule
`default_nettype wire

// ===== tb/adc_serial_port_sva.sv
`default_nettype none
module adc_serial_port_sva import adc_port_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic shiftClk,
    input wire adc_port_pkg::ctrl_pins_t pins,
    input wire logic serialCommandIn,
    input wire logic [12:0] analogCode,
    input wire logic serialDataOut,
    input wire logic conversionDone
);
    // ============================================================
    // Busy-time counter
    logic [7:0] lowCnt;

    // Cycles with a conversion running; saturates so it never wraps
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt <= 8'h00;
        end else begin
            lowCnt <= conversionDone ? 8'h00 : (lowCnt == 8'hFF ? lowCnt : lowCnt + 8'h01);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_idle_quiet;
        pins.selectN |-> !serialDataOut;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("output high while deselected");
    property p_ro_block;
        pins.readOnly [*6] |-> !$fell(conversionDone);
    endproperty
    a_ro_block: assert property (p_ro_block) else $error("conversion started in read-only mode");
    property p_sleep_block;
        pins.sleepPin [*6] |-> conversionDone;
    endproperty
    a_sleep_block: assert property (p_sleep_block) else $error("conversion running while asleep");
    property p_abort;
        $fell(pins.selectN) && !conversionDone |-> ##[1:8] conversionDone;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not ended by select");
    property p_conv_max;
        !conversionDone |-> lowCnt < 8'h6E;
    endproperty
    a_conv_max: assert property (p_conv_max) else $error("end of conversion never came");
    property p_conv_min;
        $rose(conversionDone) && pins.selectN |-> lowCnt >= 8'h32;
    endproperty
    a_conv_min: assert property (p_conv_min) else $error("conversion shorter than minimum");
    property p_start_sel;
        $fell(conversionDone) |-> !$past(pins.selectN);
    endproperty
    a_start_sel: assert property (p_start_sel) else $error("conversion started while idle");
    property p_reset_done;
        $rose(rstn) |-> conversionDone && !serialDataOut;
    endproperty
    a_reset_done: assert property (p_reset_done) else $error("wrong outputs after reset");

    c_conv: cover property ($rose(conversionDone) && pins.selectN);
    c_abort: cover property ($fell(pins.selectN) && !conversionDone);
    c_ro: cover property (pins.readOnly && !pins.selectN);
endmodule

bind adc_serial_port adc_serial_port_sva adc_serial_port_sva_i (.clk(clk), .rstn(rstn), .shiftClk(shiftClk),
    .pins(pins), .serialCommandIn(serialCommandIn), .analogCode(analogCode), .serialDataOut(serialDataOut),
    .conversionDone(conversionDone));
`default_nettype wire

// ===== tb/host_model.sv
`default_nettype none
module host_model (
    output logic shiftClk,
    output logic selectN,
    output logic cmdBit,
    input wire logic dataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    // ============================================================
    // Host end of the serial link
    logic [16:0] rx;
    event frameDone;

    // Parked: clock low, deselected
    initial begin
        shiftClk = 1'b0;
        selectN = 1'b1;
        cmdBit = 1'b0;
    end

    // One exchange; clock runs only inside it, odd phase keeps it off clk edges
    task automatic xfer(input logic [7:0] cmd, input int n, input bit keep);
        #3;
        selectN = 1'b0;
        rx = 17'h0_0000;
        for (int k = 0; k < n; k++) begin
            cmdBit = (k < 8) ? cmd[k] : ~cmdBit;
            #40 shiftClk = 1'b1;
            #40 shiftClk = 1'b0;
            rx = {rx[15:0], dataOut};
        end
        if (!keep) begin
            #40 selectN = 1'b1;
        end
        cmdBit = ~cmdBit;
        -> frameDone;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb import adc_port_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ============================================================
    // Bench
    typedef struct packed {
        logic ck;
        logic [16:0] w;
    } note_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ro = 1'b0;
    logic sl = 1'b0;
    logic [12:0] code = 13'h0000;
    logic [31:0] seed = 32'hccbc_12fb;
    logic shiftClk, selectN, cmdBit, dataOut, done;
    ctrl_pins_t pins;
    note_t notes[$];
    note_t nt;
    int fails = 0;
    int nTests = 0;
    int cyc = 0;
    int busyCnt = 0;
    int b, L = 13;
    bit M = 1'b1;
    bit keep = 1'b0;
    int lows[4];
    int acqLen[4] = '{6, 10, 18, 34};
    logic [7:0] acqCmd[4] = '{8'h70, 8'h72, 8'h71, 8'h73};

    assign pins = '{selectN: selectN, readOnly: ro, sleepPin: sl};
    always #5 clk = ~clk;

    adc_serial_port adc_serial_port_i (.clk(clk), .rstn(rstn), .shiftClk(shiftClk), .pins(pins),
        .serialCommandIn(cmdBit), .analogCode(code), .serialDataOut(dataOut), .conversionDone(done));
    host_model host_model_i (.shiftClk(shiftClk), .selectN(selectN), .cmdBit(cmdBit), .dataOut(dataOut));

    // Wire order as the host collects it, first bit at the top
    function automatic logic [16:0] seen(logic [16:0] w, int l, bit msb, int n);
        logic [16:0] r;
        r = 17'h0_0000;
        for (int k = 0; k < n; k++) begin
            r[n-1-k] = msb ? w[l-1-k] : w[k];
        end
        return r;
    endfunction

    task automatic check(string what, logic [16:0] exp, logic [16:0] got);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic endOfTest;
        $display("Comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Note what the exchange should return, then run it
    task automatic frame(logic [7:0] cmd, int n, bit ck, logic [16:0] w);
        @(posedge clk);
        notes.push_back('{ck, seen(w, L, M, n)});
        host_model_i.xfer(cmd, n, keep);
    endtask

    // Bounded wait for the end-of-conversion level
    task automatic waitFor(logic v);
        int i;
        i = 0;
        while (done !== v && i < 300) begin
            @(posedge clk);
            i++;
        end
        check("end of conversion", {16'h0000, v}, {16'h0000, done});
    endtask

    // Pairs each finished exchange with the oldest note; compares only when that note is flagged
    always @(host_model_i.frameDone) begin
        nt = notes.pop_front();
        if (nt.ck) begin
            check("serial word", nt.w, host_model_i.rx);
        end
    end

    // Cycle ceiling; also totals busy cycles for acquisition timing
    always @(posedge clk) begin
        cyc++;
        busyCnt += (done === 1'b0);
        if (cyc == 30000) begin
            fails++;
            endOfTest();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        frame(8'h30, 8, 1, 17'h0_0000);
        frame(8'h30, 13, 1, 17'h0_00D0);
        @(posedge clk);
        ro <= 1'b1;
        frame(8'h00, 13, 1, 17'h0_00D0);
        @(posedge clk);
        ro <= 1'b0;
        code <= 13'($random(seed));
        frame(8'h00, 13, 1, 17'h0_00D0);
        check("conversion start", 17'h0_0000, {16'h0000, done});
        waitFor(1'b1);
        frame(8'hB0, 13, 1, {4'h0, code});
        L = 12;
        repeat (20) @(posedge clk);
        check("no conversion", 17'h0_0001, {16'h0000, done});
        frame(8'h30, 12, 0, 17'h0_0000);
        frame(8'hB1, 12, 1, 17'h0_0090);
        L = 13;
        @(posedge clk);
        code <= 13'($random(seed));
        frame(8'h60, 13, 0, 17'h0_0000);
        waitFor(1'b1);
        L = 9;
        M = 1'b0;
        frame(8'h30, 9, 1, {8'h00, code[12], code[11:4]});
        frame(8'h30, 9, 1, 17'h0_0048);
        frame(8'h00, 9, 1, 17'h0_0048);
        L = 13;
        M = 1'b1;
        waitFor(1'b1);
        for (int s = 0; s < 4; s++) begin
            frame(acqCmd[s], 13, 0, 17'h0_0000);
            b = busyCnt;
            frame(8'h00, 13, 0, 17'h0_0000);
            waitFor(1'b1);
            lows[s] = busyCnt - b;
        end
        for (int s = 1; s < 4; s++) begin
            check("acquisition", 17'(acqLen[s] - 6), 17'(lows[s] - lows[0]));
        end
        frame(8'h72, 13, 0, 17'h0_0000);
        keep = 1'b1;
        frame(8'h30, 13, 0, 17'h0_0000);
        keep = 1'b0;
        frame(8'h30, 13, 1, 17'h0_00D0);
        frame(8'h00, 8, 0, 17'h0_0000);
        frame(8'h30, 8, 0, 17'h0_0000);
        check("aborted", 17'h0_0001, {16'h0000, done});
        @(posedge clk);
        sl <= 1'b1;
        frame(8'h00, 13, 0, 17'h0_0000);
        check("asleep", 17'h0_0001, {16'h0000, done});
        @(posedge clk);
        sl <= 1'b0;
        repeat (300) @(posedge clk);
        frame(8'hD0, 8, 0, 17'h0_0000);
        frame(8'h30, 8, 0, 17'h0_0000);
        frame(8'h50, 8, 1, 17'h0_00D2);
        frame(8'h30, 8, 0, 17'h0_0000);
        frame(8'h30, 13, 1, 17'h0_00D1);
        frame(8'h10, 13, 0, 17'h0_0000);
        frame(8'h30, 13, 0, 17'h0_0000);
        frame(8'h30, 13, 1, 17'h0_00D4);
        repeat (1200) @(posedge clk);
        frame(8'h30, 13, 1, 17'h0_00D4);
        frame(8'h00, 13, 1, 17'h0_00D0);
        waitFor(1'b1);
        // Test-mode flag in status, then a pending zero lengthens acquisition
        frame(8'hF1, 13, 0, 17'h0_0000);
        frame(8'h30, 13, 0, 17'h0_0000);
        frame(8'h90, 13, 1, 17'h0_01D0);
        frame(8'hF0, 13, 0, 17'h0_0000);
        b = busyCnt;
        frame(8'h00, 13, 0, 17'h0_0000);
        waitFor(1'b1);
        check("zero acquisition", 17'(lows[1] + ZERO_CYCLES), 17'(busyCnt - b));
        frame(8'h30, 13, 0, 17'h0_0000);
        frame(8'h30, 13, 1, 17'h0_00D0);
        endOfTest();
    end
endmodule
`default_nettype wire
